// ===== pwm_hiccup_ctrl.sv
`timescale 1ns/1ps
`include "pwm_defs.svh"

// Contract
// - Overcurrent while high side is on ends the switching pulse at once.
// - After termination high side stays off until the next cycle starts.
// - Fault counter rises on an overcurrent cycle, falls on a clean one.
// - Count of seven issues restart and seven soft-start cycles.
// - Both gate drives stay off throughout the hiccup sequence.
// - One decrement per soft-start cycle; switching resumes at zero.
// - Persisting overload counts again and re-enters hiccup at seven.
// - An applied sync clock replaces the internal oscillator.
// - Sync held low selects free-running internal oscillator.
// - Seven sync pulses before ramp completes declare undervoltage, disable PWM.
// - A clock before the ramp reaches 90 percent is an undervoltage cycle.
// - Seven long-ramp cycles start; seven short-ramp cycles lock out.
module pwm_hiccup_ctrl #(
  parameter int FREE_RUN_CYCLES = `FREE_RUN_PERIOD_NS / `CLK_PERIOD_NS,
  parameter int SS_CYCLE_TICKS = `SS_CYCLE_TICKS,
  parameter int SSW = 9
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic oc_trip_in,
  input wire logic ramp_done_in,
  input wire logic pwm_end_in,
  input wire logic sync_in,
  output pwm_pkg::gate_drive_t gates,
  output logic soft_start_req,
  output pwm_pkg::pwm_status_t status
);

  // ============================================================
  // Input synchronisers
  // ============================================================
  logic [`LANES-1:0] meta_reg;
  logic [`LANES-1:0] sync_reg;
  logic oc_s;
  logic ramp_s;
  logic pwm_end_s;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= {sync_in, pwm_end_in, ramp_done_in, oc_trip_in};
      sync_reg <= meta_reg;
    end
  end

  assign oc_s = sync_reg[`LANE_OC];
  assign ramp_s = sync_reg[`LANE_RAMP];
  assign pwm_end_s = sync_reg[`LANE_PWM_END];

  // ============================================================
  // Master clock
  // ============================================================
  logic master_tick;
  logic sync_mode;

  master_clk_select #(
    .FREE_RUN_CYCLES(FREE_RUN_CYCLES)
  ) u_clk_select (
    .core_clk(core_clk),
    .rstn(rstn),
    .sync_level(sync_reg[`LANE_SYNC]),
    .master_tick(master_tick),
    .sync_mode(sync_mode)
  );

  // Saturating three-bit step, shared by the fault and ramp counters.
  function automatic logic [2:0] sat_step(input logic [2:0] cnt,
                                          input logic up);
    logic [2:0] res;
    res = cnt;
    if (up && cnt != `FAULT_LIMIT) begin
      res = cnt + `CNT_ONE;
    end else if (!up && cnt != `CNT_ZERO) begin
      res = cnt - `CNT_ONE;
    end
    return res;
  endfunction

  // ============================================================
  // Per-cycle event flags
  // ============================================================
  pwm_pkg::ctrl_state_t state_reg;
  logic hs_on_reg;
  logic oc_term;
  logic oc_seen_reg;
  logic ramp_seen_reg;
  logic cycle_oc;
  logic cycle_ramp_ok;

  assign oc_term = oc_s && hs_on_reg;
  assign cycle_oc = oc_seen_reg || oc_term;
  assign cycle_ramp_ok = ramp_seen_reg || ramp_s;

  // An event in the tick cycle reaches the ending cycle's verdict through
  // the combined terms above, so the end-of-cycle clear never loses it.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      oc_seen_reg <= 1'b0;
      ramp_seen_reg <= 1'b0;
    end else if (master_tick) begin
      oc_seen_reg <= 1'b0;
      ramp_seen_reg <= 1'b0;
    end else begin
      oc_seen_reg <= oc_seen_reg || oc_term;
      ramp_seen_reg <= ramp_seen_reg || ramp_s;
    end
  end

  // ============================================================
  // Control state
  // ============================================================
  logic [2:0] fault_reg;
  logic [2:0] fault_next;
  logic [2:0] uv_reg;
  logic [2:0] uv_next;
  logic [SSW-1:0] ss_cnt_reg;
  logic ss_done;
  logic power_good_reg;

  assign ss_done = master_tick && ss_cnt_reg == SSW'(SS_CYCLE_TICKS - 1);
  assign fault_next = sat_step(fault_reg, cycle_oc);
  assign uv_next = (state_reg == pwm_pkg::ST_LOCKOUT) ?
                   sat_step(uv_reg, cycle_ramp_ok) :
                   sat_step(uv_reg, !cycle_ramp_ok);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= pwm_pkg::ST_LOCKOUT;
    end else if (master_tick) begin
      unique case (state_reg)
        pwm_pkg::ST_LOCKOUT: begin
          if (uv_next == `UV_LIMIT) begin
            state_reg <= pwm_pkg::ST_RUN;
          end
        end
        pwm_pkg::ST_RUN: begin
          if (uv_next == `UV_LIMIT) begin
            state_reg <= pwm_pkg::ST_LOCKOUT;
          end else if (fault_next == `FAULT_LIMIT) begin
            state_reg <= pwm_pkg::ST_HICCUP;
          end
        end
        pwm_pkg::ST_HICCUP: begin
          if (uv_next == `UV_LIMIT) begin
            state_reg <= pwm_pkg::ST_LOCKOUT;
          end else if (ss_done && fault_reg == `CNT_ONE) begin
            state_reg <= pwm_pkg::ST_RUN;
          end
        end
      endcase
    end
  end

  // Ramp-versus-clock counter; restarts from zero on every entry to or exit from lockout.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      uv_reg <= `CNT_ZERO;
    end else if (master_tick) begin
      uv_reg <= (uv_next == `UV_LIMIT) ? `CNT_ZERO : uv_next;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fault_reg <= `CNT_ZERO;
    end else if (master_tick) begin
      if (state_reg == pwm_pkg::ST_RUN) begin
        fault_reg <= fault_next;
      end else if (state_reg == pwm_pkg::ST_HICCUP && ss_done) begin
        fault_reg <= sat_step(fault_reg, 1'b0);
      end else if (state_reg == pwm_pkg::ST_LOCKOUT) begin
        fault_reg <= `CNT_ZERO;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ss_cnt_reg <= '0;
    end else if (state_reg != pwm_pkg::ST_HICCUP || ss_done) begin
      ss_cnt_reg <= '0;
    end else if (master_tick) begin
      ss_cnt_reg <= ss_cnt_reg + SSW'(1);
    end
  end

  // Soft-start request: once on leaving lockout, and at the start of each
  // soft-start cycle of a hiccup except after the last one.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      soft_start_req <= 1'b0;
    end else begin
      soft_start_req <= master_tick && (
        (state_reg == pwm_pkg::ST_LOCKOUT && uv_next == `UV_LIMIT) ||
        (state_reg == pwm_pkg::ST_RUN && uv_next != `UV_LIMIT &&
         fault_next == `FAULT_LIMIT) ||
        (state_reg == pwm_pkg::ST_HICCUP && uv_next != `UV_LIMIT &&
         ss_done && fault_reg != `CNT_ONE));
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      power_good_reg <= 1'b0;
    end else begin
      power_good_reg <= (state_reg != pwm_pkg::ST_LOCKOUT);
    end
  end

  // ============================================================
  // Gate drives
  // ============================================================
  logic hs_next;
  logic ls_reg;
  logic leave_run;

  // A tick that ends RUN must not start a pulse, or a low-side on cycle, that the
  // new state would then show for one cycle with its gates meant to be off.
  assign leave_run = master_tick && state_reg == pwm_pkg::ST_RUN &&
                     (uv_next == `UV_LIMIT || fault_next == `FAULT_LIMIT);

  always_comb begin
    hs_next = hs_on_reg;
    if (state_reg != pwm_pkg::ST_RUN || leave_run) begin
      hs_next = 1'b0;
    end else if (oc_term || pwm_end_s) begin
      hs_next = 1'b0;
    end else if (master_tick) begin
      hs_next = 1'b1;
    end
  end

  // The low side waits one clock after the high side turns off, a dead
  // cycle that prevents cross conduction in the external switches.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hs_on_reg <= 1'b0;
      ls_reg <= 1'b0;
    end else begin
      hs_on_reg <= hs_next;
      ls_reg <= (state_reg == pwm_pkg::ST_RUN) && !leave_run && !hs_next &&
                !hs_on_reg;
    end
  end

  assign gates.high_side = hs_on_reg;
  assign gates.low_side = ls_reg;
  assign status.power_good = power_good_reg;
  assign status.undervoltage_lockout = !power_good_reg;
  assign status.hiccup_active = (state_reg == pwm_pkg::ST_HICCUP);
  assign status.sync_mode = sync_mode;
  assign status.fault_count = fault_reg;

  // ============================================================
  // Checks
  // ============================================================
  a_oc_ends_pulse: assert property (
    @(posedge core_clk) disable iff (!rstn)
    oc_s && gates.high_side |=> !gates.high_side)
    else $error("overcurrent did not end the pulse");

  a_hs_starts_tick: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $rose(gates.high_side) |-> $past(master_tick) &&
    $past(state_reg) == pwm_pkg::ST_RUN)
    else $error("high side turned on outside a cycle start");

  a_fault_counts_up: assert property (
    @(posedge core_clk) disable iff (!rstn)
    master_tick && state_reg == pwm_pkg::ST_RUN && cycle_oc &&
    fault_reg != `FAULT_LIMIT |=> fault_reg == $past(fault_reg) + `CNT_ONE)
    else $error("fault counter did not increment");

  a_fault_floor: assert property (
    @(posedge core_clk) disable iff (!rstn)
    master_tick && state_reg == pwm_pkg::ST_RUN && !cycle_oc
    |=> fault_reg == (($past(fault_reg) == `CNT_ZERO) ? `CNT_ZERO :
                      $past(fault_reg) - `CNT_ONE))
    else $error("fault counter clean-cycle step wrong");

  a_hiccup_entry: assert property (
    @(posedge core_clk) disable iff (!rstn)
    master_tick && state_reg == pwm_pkg::ST_RUN && cycle_oc &&
    fault_reg == `CNT_PRELIMIT && uv_next != `UV_LIMIT
    |=> state_reg == pwm_pkg::ST_HICCUP && soft_start_req)
    else $error("seventh fault did not start hiccup");

  a_hiccup_gates_off: assert property (
    @(posedge core_clk) disable iff (!rstn)
    state_reg == pwm_pkg::ST_HICCUP |-> !gates.high_side && !gates.low_side)
    else $error("gate driven during hiccup");

  a_hiccup_exit: assert property (
    @(posedge core_clk) disable iff (!rstn)
    state_reg == pwm_pkg::ST_HICCUP && ss_done && fault_reg == `CNT_ONE &&
    uv_next != `UV_LIMIT |=> state_reg == pwm_pkg::ST_RUN &&
    fault_reg == `CNT_ZERO)
    else $error("hiccup did not end at zero");

  a_uv_lockout: assert property (
    @(posedge core_clk) disable iff (!rstn)
    master_tick && state_reg == pwm_pkg::ST_RUN && !cycle_ramp_ok &&
    uv_reg == `CNT_PRELIMIT |=> state_reg == pwm_pkg::ST_LOCKOUT
    ##1 !gates.high_side && !power_good_reg)
    else $error("short ramps did not lock out");

  a_start_after_seven: assert property (
    @(posedge core_clk) disable iff (!rstn)
    master_tick && state_reg == pwm_pkg::ST_LOCKOUT && cycle_ramp_ok &&
    uv_reg == `CNT_PRELIMIT |=> soft_start_req ##1 power_good_reg)
    else $error("start-up did not follow seven good ramps");

  c_hiccup_seen: cover property (
    @(posedge core_clk) disable iff (!rstn)
    $rose(status.hiccup_active));
  c_hiccup_recover: cover property (
    @(posedge core_clk) disable iff (!rstn)
    $fell(status.hiccup_active) && state_reg == pwm_pkg::ST_RUN);
  c_oc_terminate: cover property (
    @(posedge core_clk) disable iff (!rstn) oc_term);
  c_sync_lockout: cover property (
    @(posedge core_clk) disable iff (!rstn)
    sync_mode && $rose(status.undervoltage_lockout));

endmodule

// ===== pwm_defs.svh
`ifndef PWM_DEFS_SVH
`define PWM_DEFS_SVH

// ============================================================
// Timing
// ============================================================
`define CLK_PERIOD_NS 25
`define FREE_RUN_PERIOD_NS 3333
`define SYNC_LOSS_PERIODS 2
`define SS_CYCLE_TICKS 256

// ============================================================
// Counter limits
// ============================================================
`define FAULT_LIMIT 3'h7
`define UV_LIMIT 3'h7
`define CNT_ZERO 3'h0
`define CNT_ONE 3'h1
`define CNT_PRELIMIT 3'h6

// ============================================================
// Synchroniser lanes
// ============================================================
`define LANE_OC 0
`define LANE_RAMP 1
`define LANE_PWM_END 2
`define LANE_SYNC 3
`define LANES 4

`endif

// ===== pwm_pkg.sv
package pwm_pkg;

  typedef enum logic [2:0] {
    ST_LOCKOUT = 3'h1,
    ST_RUN = 3'h2,
    ST_HICCUP = 3'h4
  } ctrl_state_t;

  typedef struct packed {
    logic high_side;
    logic low_side;
  } gate_drive_t;

  typedef struct packed {
    logic power_good;
    logic undervoltage_lockout;
    logic hiccup_active;
    logic sync_mode;
    logic [2:0] fault_count;
  } pwm_status_t;

endpackage

// ===== master_clk_select.sv
`timescale 1ns/1ps
`include "pwm_defs.svh"

module master_clk_select #(
  parameter int FREE_RUN_CYCLES = `FREE_RUN_PERIOD_NS / `CLK_PERIOD_NS,
  parameter int SYNC_LOSS_CYCLES = FREE_RUN_CYCLES * `SYNC_LOSS_PERIODS,
  parameter int CW = 16
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sync_level,
  output logic master_tick,
  output logic sync_mode
);

  logic sync_prev_reg;
  logic sync_rise;
  logic [CW-1:0] osc_cnt_reg;
  logic [CW-1:0] loss_cnt_reg;
  logic osc_wrap;

  assign sync_rise = sync_level && !sync_prev_reg;
  assign osc_wrap = (osc_cnt_reg == CW'(FREE_RUN_CYCLES - 1));

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync_prev_reg <= 1'b0;
    end else begin
      sync_prev_reg <= sync_level;
    end
  end

  // Internal oscillator; restarts its period on each sync edge so that a
  // lost sync clock hands over without a short cycle.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      osc_cnt_reg <= '0;
    end else if (osc_wrap || sync_rise) begin
      osc_cnt_reg <= '0;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + CW'(1);
    end
  end

  // A held-low sync pin lets the loss counter expire: free-running.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      loss_cnt_reg <= '0;
      sync_mode <= 1'b0;
    end else if (sync_rise) begin
      loss_cnt_reg <= '0;
      sync_mode <= 1'b1;
    end else if (loss_cnt_reg == CW'(SYNC_LOSS_CYCLES - 1)) begin
      sync_mode <= 1'b0;
    end else begin
      loss_cnt_reg <= loss_cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      master_tick <= 1'b0;
    end else begin
      master_tick <= sync_rise || (osc_wrap && !sync_mode);
    end
  end

  // ============================================================
  // Checks
  // ============================================================
  a_sync_edge_ticks: assert property (
    @(posedge core_clk) disable iff (!rstn)
    sync_rise |=> master_tick && sync_mode)
    else $error("sync edge did not produce a master tick");

  a_free_run_tick: assert property (
    @(posedge core_clk) disable iff (!rstn)
    master_tick && !$past(sync_rise) |-> $past(osc_wrap) && !$past(sync_mode))
    else $error("free-run tick not at oscillator wrap");

endmodule

// ===== pwm_far_side.sv
`timescale 1ns/1ps

// ============================================================
// Far side: gate drivers, comparators and sync clock source
// ============================================================
module pwm_far_side #(
  parameter int SYNC_PERIOD_NS = 200
) (
  input wire logic core_clk,
  input wire pwm_pkg::gate_drive_t gates,
  input wire logic overload,
  input wire logic ramp_ok,
  input wire logic [3:0] duty,
  input wire logic [1:0] oc_delay,
  input wire logic sync_en,
  output logic oc_trip_in,
  output logic ramp_done_in,
  output logic pwm_end_in,
  output logic sync_in
);
  logic [3:0] on_cnt;

  always @(negedge core_clk) begin
    if (gates.high_side) begin
      on_cnt <= on_cnt + 4'h1;
    end else begin
      on_cnt <= 4'h0;
    end
  end

  // The switch drop is only sensed while the high side conducts, so the
  // comparator falls as soon as the gate is released.
  always @(negedge core_clk) begin
    oc_trip_in <= overload && gates.high_side && on_cnt >= {2'h0, oc_delay};
    pwm_end_in <= gates.high_side && on_cnt >= duty;
    ramp_done_in <= ramp_ok;
  end

  // A 200 ns period runs 25 percent faster than the 250 ns free run.
  initial begin
    forever begin
      if (sync_en) begin
        sync_in = 1'b1;
        #(SYNC_PERIOD_NS / 2);
        sync_in = 1'b0;
        #(SYNC_PERIOD_NS / 2);
      end else begin
        sync_in = 1'b0;
        @(posedge sync_en);
        #7;
      end
    end
  end
endmodule

// ===== pwm_overcurrent_hiccup_sync_bench.sv
`timescale 1ns/1ps

module pwm_overcurrent_hiccup_sync_bench;
  // ============================================================
  // Signals
  // ============================================================
  localparam int FR = 10;
  localparam int SS = 2;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic overload = 1'b0;
  logic ramp_ok = 1'b0;
  logic sync_en = 1'b0;
  logic [3:0] duty = 4'h2;
  logic [1:0] oc_delay = 2'h1;
  logic ovl_set = 1'b0;
  logic [3:0] duty_set = 4'h2;
  logic [1:0] ocd_set = 2'h1;
  logic oc_trip_in;
  logic ramp_done_in;
  logic pwm_end_in;
  logic sync_in;
  logic soft_start_req;
  pwm_pkg::gate_drive_t gates;
  pwm_pkg::pwm_status_t status;
  logic [31:0] rnd = 32'hBB07;
  logic rnd_on = 1'b0;
  logic fault_mon = 1'b0;
  logic hs_prev = 1'b0;
  logic pg_prev = 1'b0;
  logic [2:0] fault_prev = 3'h0;
  int gap_cnt = 0;
  int last_gap = 0;
  int ss_cnt = 0;
  int oc_run = 0;
  int miscompares = 0;
  int checks_done = 0;

  pwm_hiccup_ctrl #(.FREE_RUN_CYCLES(FR), .SS_CYCLE_TICKS(SS), .SSW(9)) DUT (
    .core_clk(core_clk),
    .rstn(rstn),
    .oc_trip_in(oc_trip_in),
    .ramp_done_in(ramp_done_in),
    .pwm_end_in(pwm_end_in),
    .sync_in(sync_in),
    .gates(gates),
    .soft_start_req(soft_start_req),
    .status(status)
  );

  pwm_far_side #(.SYNC_PERIOD_NS(200)) far_side (
    .core_clk(core_clk),
    .gates(gates),
    .overload(overload),
    .ramp_ok(ramp_ok),
    .duty(duty),
    .oc_delay(oc_delay),
    .sync_en(sync_en),
    .oc_trip_in(oc_trip_in),
    .ramp_done_in(ramp_done_in),
    .pwm_end_in(pwm_end_in),
    .sync_in(sync_in)
  );

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  // ============================================================
  // Helpers
  // ============================================================
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Latest moment a change may land, in core clock cycles, for a span given in switching cycles.
  function automatic int bound(input int ticks);
    return ticks * FR + 30;
  endfunction

  function automatic logic sel(input int k);
    case (k)
      0: return status.power_good;
      1: return status.hiccup_active;
      2: return status.sync_mode;
      3: return status.undervoltage_lockout;
      default: return status.fault_count == 3'h0;
    endcase
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_lvl(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (sel(k) !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    chk(8'(sel(k)), 8'(v));
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic close_out();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ============================================================
  // Monitor and random stimulus
  // ============================================================
  always @(negedge core_clk) begin
    int d;
    if (rnd_on) begin
      rnd <= lfsr_next(rnd);
      overload <= rnd[2:0] == 3'h0;
      duty <= {2'h0, rnd[4:3]} + 4'h1;
      oc_delay <= rnd[6:5];
    end else begin
      overload <= ovl_set;
      duty <= duty_set;
      oc_delay <= ocd_set;
    end
    if (status.hiccup_active || status.undervoltage_lockout) begin
      chk(8'(gates), 8'h00);
    end
    if (oc_trip_in && gates.high_side) oc_run = oc_run + 1;
    else oc_run = 0;
    if (oc_run > 3) chk(8'(gates.high_side), 8'h00);
    if (gates.high_side && !hs_prev) begin
      last_gap = gap_cnt;
      gap_cnt = 1;
    end else begin
      gap_cnt = gap_cnt + 1;
    end
    if (soft_start_req) ss_cnt = ss_cnt + 1;
    // Lockout clears the count in one step, so that phase is not watched.
    if (fault_mon && pg_prev && status.power_good &&
        status.fault_count !== fault_prev) begin
      d = int'(status.fault_count) - int'(fault_prev);
      chk(8'(d == 1 || d == -1), 8'h01);
    end
    hs_prev = gates.high_side;
    pg_prev = status.power_good;
    fault_prev = status.fault_count;
  end

  initial begin
    #(25 * 8000);
    miscompares++;
    close_out();
  end

  // ============================================================
  // Scenarios
  // ============================================================
  initial begin
    cycles(5);
    chk(8'(status), 8'h20);
    chk(8'(gates), 8'h00);
    rstn = 1'b1;
    ramp_ok = 1'b1;
    wait_lvl(0, 1'b1, bound(9));
    chk(8'(ss_cnt), 8'h01);
    fault_mon = 1'b1;
    rnd_on = 1'b1;
    cycles(400);
    rnd_on = 1'b0;
    cycles(1);
    ovl_set = 1'b0;
    wait_lvl(1, 1'b0, bound(7 * SS + 1));
    wait_lvl(4, 1'b1, bound(8));
    cycles(3 * FR);
    chk(8'(status.fault_count), 8'h00);
    ss_cnt = 0;
    duty_set = 4'h4;
    ocd_set = 2'h0;
    ovl_set = 1'b1;
    cycles(4 * FR + 5);
    chk(8'(last_gap), 8'(FR));
    wait_lvl(1, 1'b1, bound(8));
    wait_lvl(1, 1'b0, bound(7 * SS + 1));
    chk(8'(ss_cnt), 8'h07);
    chk(8'(status.fault_count), 8'h00);
    wait_lvl(1, 1'b1, bound(9));
    ovl_set = 1'b0;
    duty_set = 4'h2;
    wait_lvl(1, 1'b0, bound(7 * SS + 1));
    cycles(3 * FR);
    chk(8'(status[6:4]), 8'h04);
    sync_en = 1'b1;
    wait_lvl(2, 1'b1, 30);
    cycles(4 * FR);
    chk(8'(last_gap), 8'h08);
    sync_en = 1'b0;
    wait_lvl(2, 1'b0, 3 * FR + 10);
    cycles(3 * FR);
    chk(8'(last_gap), 8'(FR));
    fault_mon = 1'b0;
    sync_en = 1'b1;
    cycles(3 * FR);
    ramp_ok = 1'b0;
    wait_lvl(3, 1'b1, 9 * 8 + 30);
    chk(8'(status.power_good), 8'h00);
    ss_cnt = 0;
    ramp_ok = 1'b1;
    wait_lvl(0, 1'b1, 9 * 8 + 30);
    chk(8'(ss_cnt), 8'h01);
    sync_en = 1'b0;
    close_out();
  end
endmodule
